// *** dv/vsense_config_tb.sv ***
`timescale 1ns/100ps
module vsense_config_tb;
    import vsense_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                    clk;
    logic                    rst;
    logic                    ce;
    logic [7:0]              addr;
    logic                    wr;
    logic                    rd;
    logic [7:0]              wdata;
    logic [SAMPLE_WIDTH-1:0] sample;
    logic [7:0]              rdata;
    logic [7:0]              active;
    logic                    tick;
    logic                    flag;
    int                      bad_count;
    int                      num_checks;
    int                      cycles;

    vsense_config vsense_config_i (
        .REF_CLK_IN          (clk),
        .RST_IN              (rst),
        .CE_IN               (ce),
        .REG_ADDR_IN         (addr),
        .REG_WR_IN           (wr),
        .REG_RD_IN           (rd),
        .REG_WDATA_IN        (wdata),
        .SAMPLE_AVG_IN       (sample),
        .REG_RDATA_OUT       (rdata),
        .SETPOINT_ACTIVE_OUT (active),
        .SAMPLE_TICK_OUT     (tick),
        .OV_FLAG_OUT         (flag)
    );

    // ------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask : reg_read

    task automatic tick_sample(input logic [SAMPLE_WIDTH-1:0] v, input logic exp);
        int n;
        @(posedge clk);
        sample <= v;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 4100);
        check({15'h0000, tick}, 16'h0001);
        @(posedge clk);
        #1;
        check({15'h0000, flag}, {15'h0000, exp});
    endtask : tick_sample

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst        = 1'b1;
        ce         = 1'b1;
        addr       = 8'h00;
        wr         = 1'b0;
        rd         = 1'b0;
        wdata      = 8'h00;
        sample     = 12'h000;
        bad_count  = 0;
        num_checks = 0;
        cycles     = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({8'h00, active}, 16'h00A5);
        reg_read(ADDR_SETPOINT, 8'hA5);
        reg_read(ADDR_OV_LIMIT, 8'h00);
        reg_write(ADDR_SETPOINT, 8'hFF);
        reg_read(ADDR_SETPOINT, 8'hFF);
        check({8'h00, active}, 16'h00A5);
        reg_write(ADDR_COMMIT, 8'hFE);
        check({8'h00, active}, 16'h00A5);
        reg_write(ADDR_COMMIT, 8'h01);
        check({8'h00, active}, 16'h00FF);
        reg_read(ADDR_COMMIT, 8'h00);
        reg_read(8'h40, 8'h00);
        reg_write(8'h40, 8'h12);
        reg_read(ADDR_SETPOINT, 8'hFF);
        // Enable low: writes, commits and reads are not taken
        @(posedge clk);
        ce <= 1'b0;
        reg_write(ADDR_SETPOINT, 8'h3C);
        reg_write(ADDR_COMMIT, 8'h01);
        reg_read(ADDR_OV_LIMIT, 8'hFF);
        check({8'h00, active}, 16'h00FF);
        @(posedge clk);
        ce <= 1'b1;
        reg_read(ADDR_SETPOINT, 8'hFF);
        // Code 31 with reserved bit set, one sample
        reg_write(ADDR_OV_LIMIT, 8'hFC);
        reg_read(ADDR_OV_LIMIT, 8'hFC);
        tick_sample(12'hF01, 1'b1);
        tick_sample(12'hF00, 1'b0);
        // Code 0, each sample count in turn
        for (int c = 0; c < 4; c++) begin
            reg_write(ADDR_OV_LIMIT, 8'(c));
            tick_sample(12'hB20, 1'b0);
            if (c == 3) begin
                tick_sample(12'hB21, 1'b0);
                tick_sample(12'hB21, 1'b0);
                tick_sample(12'h7D0, 1'b0);
            end
            for (int k = 0; k < c; k++) begin
                tick_sample(12'hB21, 1'b0);
            end
            tick_sample(12'hB21, 1'b1);
        end
        // Mid-run reset brings the defaults back
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        check({15'h0000, flag}, 16'h0000);
        check({8'h00, active}, 16'h00A5);
        check({8'h00, rdata}, 16'h0000);
        reg_read(ADDR_SETPOINT, 8'hA5);
        reg_read(ADDR_OV_LIMIT, 8'h00);
        print_verdict();
    end
endmodule : vsense_config_tb

// *** src/ov_run_detect.sv ***
`timescale 1ns/100ps
module ov_run_detect
    import vsense_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       sample_in,
    input  wire logic       exceed_in,
    input  wire logic [1:0] need_in,
    output logic            flag_out
);

    run_state_type st_reg;
    run_state_type st_next;
    logic [2:0]    target;

    assign target = {1'b0, need_in} + 3'h1;

    // ------------------------------------------------------------
    // Consecutive exceed counter
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (sample_in) begin
            if (exceed_in) begin
                st_next.run  = (st_reg.run >= target) ? target : st_reg.run + 3'h1;
                st_next.flag = ((st_reg.run + 3'h1) >= target);
            end else begin
                st_next.run  = 3'h0;
                st_next.flag = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end

    assign flag_out = st_reg.flag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_miss_clears_run: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && sample_in && !exceed_in |=> st_reg.run == 3'h0 && !st_reg.flag)
        else $error("run not cleared after a miss");

    a_flag_needs_run: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && sample_in && exceed_in && (st_reg.run + 3'h1) < target |=> !st_reg.flag)
        else $error("flag set before full run");

    a_flag_on_run: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && sample_in && exceed_in && (st_reg.run + 3'h1) >= target |=> st_reg.flag)
        else $error("flag missing after full run");

endmodule : ov_run_detect

// *** src/vsense_config.sv ***
`timescale 1ns/100ps
// Contract
// - Setpoint is 8-bit code, 0.6% per step
// - Setpoint resets to 0xA5, 100% nominal
// - Setpoint write only updates shadow copy
// - Commit bit 0x5D[0] copies shadow to active
// - Limit code bits 7:3, 107.7% plus 1.21%/step
// - Threshold is (89 + code)/128 of full scale
// - Code 31 gives 145.2% limit
// - Compare 80 us averaged sample to threshold
// - Bits 1:0 select one to four samples
// - Every selected consecutive sample must exceed
module vsense_config
    import vsense_pkg::*;
(
    input  wire logic                    REF_CLK_IN,
    input  wire logic                    RST_IN,
    input  wire logic                    CE_IN,
    input  wire logic [7:0]              REG_ADDR_IN,
    input  wire logic                    REG_WR_IN,
    input  wire logic                    REG_RD_IN,
    input  wire logic [7:0]              REG_WDATA_IN,
    input  wire logic [SAMPLE_WIDTH-1:0] SAMPLE_AVG_IN,
    output logic [7:0]                   REG_RDATA_OUT,
    output logic [7:0]                   SETPOINT_ACTIVE_OUT,
    output logic                         SAMPLE_TICK_OUT,
    output logic                         OV_FLAG_OUT
);

    reg_req_type   req;
    top_state_type st_reg;
    top_state_type st_next;
    logic          exceed;

    assign req = '{addr: REG_ADDR_IN, wr: REG_WR_IN, rd: REG_RD_IN, wdata: REG_WDATA_IN};

    // ------------------------------------------------------------
    // Register file, sample timer, threshold
    // ------------------------------------------------------------
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (req.wr) begin
            case (req.addr)
                ADDR_SETPOINT: st_next.setpoint_shadow = req.wdata;
                ADDR_OV_LIMIT: st_next.ov_limit        = req.wdata;
                ADDR_COMMIT: begin
                    if (req.wdata[COMMIT_BIT]) begin
                        st_next.setpoint_active = st_reg.setpoint_shadow;
                    end
                end
                default: st_next.ov_limit = st_reg.ov_limit;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                ADDR_SETPOINT: st_next.rdata = st_reg.setpoint_shadow;
                ADDR_OV_LIMIT: st_next.rdata = st_reg.ov_limit;
                default:       st_next.rdata = 8'h00;
            endcase
        end
        // One averaged sample every 80 us
        if (st_reg.tick_cnt == 12'(SAMPLE_CYCLES - 1)) begin
            st_next.tick_cnt = 12'h000;
            st_next.tick     = 1'b1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt + 12'h001;
        end
        // (89 + code)/128 of full scale, as a sample code
        st_next.threshold = SAMPLE_WIDTH'(THRESH_BASE
                                          + 7'(st_reg.ov_limit[OV_CODE_MSB:OV_CODE_LSB]))
                            << THRESH_SHIFT;
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            st_reg                 <= '0;
            st_reg.setpoint_shadow <= SETPOINT_RESET;
            st_reg.setpoint_active <= SETPOINT_RESET;
            st_reg.ov_limit        <= OV_LIMIT_RESET;
            st_reg.threshold       <= SAMPLE_WIDTH'(THRESH_BASE) << THRESH_SHIFT;
        end else if (CE_IN) begin
            st_reg <= st_next;
        end
    end

    assign exceed = (SAMPLE_AVG_IN > st_reg.threshold);

    ov_run_detect ov_run_detect_i (
        .clk_in    (REF_CLK_IN),
        .rst_in    (RST_IN),
        .ce_in     (CE_IN),
        .sample_in (st_reg.tick),
        .exceed_in (exceed),
        .need_in   (st_reg.ov_limit[COUNT_MSB:COUNT_LSB]),
        .flag_out  (OV_FLAG_OUT)
    );

    assign REG_RDATA_OUT       = st_reg.rdata;
    assign SETPOINT_ACTIVE_OUT = st_reg.setpoint_active;
    assign SAMPLE_TICK_OUT     = st_reg.tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [12:0] gap_cnt;
    // Enabled cycles since reset or since the last tick
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            gap_cnt <= '0;
        end else if (CE_IN && st_reg.tick) begin
            gap_cnt <= 13'h0001;
        end else if (CE_IN && gap_cnt != 13'h1FFF) begin
            gap_cnt <= gap_cnt + 13'h0001;
        end
    end

    sequence s_commit_write;
        CE_IN && req.wr && req.addr == ADDR_COMMIT && req.wdata[COMMIT_BIT];
    endsequence

    sequence s_commit_idle;
        CE_IN && req.wr && req.addr == ADDR_COMMIT && !req.wdata[COMMIT_BIT];
    endsequence

    sequence s_setpoint_write;
        CE_IN && req.wr && req.addr == ADDR_SETPOINT;
    endsequence

    sequence s_read_setpoint;
        CE_IN && req.rd && req.addr == ADDR_SETPOINT;
    endsequence

    sequence s_read_limit;
        CE_IN && req.rd && req.addr == ADDR_OV_LIMIT;
    endsequence

    sequence s_read_other;
        CE_IN && req.rd && req.addr != ADDR_SETPOINT && req.addr != ADDR_OV_LIMIT;
    endsequence

    a_reset_setpoint: assert property (@(posedge REF_CLK_IN)
        $fell(RST_IN) |-> st_reg.setpoint_active == 8'hA5)
        else $error("active setpoint not 0xA5 after reset");

    a_shadow_isolated: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !(req.wr && req.addr == ADDR_COMMIT) |=> $stable(st_reg.setpoint_active))
        else $error("active setpoint moved without commit");

    a_commit_copy: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_commit_write |=> st_reg.setpoint_active == $past(st_reg.setpoint_shadow))
        else $error("commit did not copy shadow");

    a_threshold_formula: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CE_IN ##1 $stable(st_reg.ov_limit) |-> st_reg.threshold ==
            SAMPLE_WIDTH'((89 + st_reg.ov_limit[7:3]) * 32))
        else $error("threshold mismatch");

    a_max_code: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CE_IN && st_reg.ov_limit[7:3] == 5'h1F |=> st_reg.threshold == 12'hF00)
        else $error("max code threshold wrong");

    a_tick_period: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CE_IN && st_reg.tick |-> gap_cnt == 13'(SAMPLE_CYCLES))
        else $error("sample tick early");

    a_tick_spacing: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CE_IN && gap_cnt == 13'(SAMPLE_CYCLES + 1) |-> 1'b0)
        else $error("sample tick overdue");

    a_reserved_kept: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CE_IN && req.wr && req.addr == ADDR_OV_LIMIT |=>
            st_reg.ov_limit[RESERVED_BIT] == $past(req.wdata[RESERVED_BIT]))
        else $error("reserved bit not stored");

    // ------------------------------------------------------------
    // Register access checks
    // ------------------------------------------------------------
    a_shadow_write: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_setpoint_write |=> st_reg.setpoint_shadow == $past(req.wdata))
        else $error("shadow setpoint not written");

    a_commit_needs_bit: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_commit_idle |=> $stable(st_reg.setpoint_active))
        else $error("commit without bit moved setpoint");

    a_read_setpoint: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_read_setpoint |=> st_reg.rdata == $past(st_reg.setpoint_shadow))
        else $error("setpoint read data wrong");

    a_read_limit: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_read_limit |=> st_reg.rdata == $past(st_reg.ov_limit))
        else $error("limit read data wrong");

    a_read_other: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_read_other |=> st_reg.rdata == 8'h00)
        else $error("unmapped read not zero");

    a_rdata_hold: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !(CE_IN && req.rd) |=> $stable(st_reg.rdata))
        else $error("read data moved without read");

    a_reset_registers: assert property (@(posedge REF_CLK_IN)
        $fell(RST_IN) |-> st_reg.setpoint_shadow == SETPOINT_RESET
            && st_reg.ov_limit == OV_LIMIT_RESET && st_reg.rdata == 8'h00)
        else $error("register defaults wrong after reset");

    // ------------------------------------------------------------
    // Timer, flag and freeze checks
    // ------------------------------------------------------------
    a_reset_outputs: assert property (@(posedge REF_CLK_IN)
        $fell(RST_IN) |-> !st_reg.tick && !OV_FLAG_OUT && st_reg.tick_cnt == 12'h000)
        else $error("timer or flag not cleared by reset");

    a_tick_single: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CE_IN && st_reg.tick |=> !st_reg.tick)
        else $error("sample tick longer than a cycle");

    a_flag_on_tick: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CE_IN && !st_reg.tick |=> $stable(OV_FLAG_OUT))
        else $error("flag moved between samples");

    a_miss_clears_flag: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CE_IN && st_reg.tick && SAMPLE_AVG_IN <= st_reg.threshold |=> !OV_FLAG_OUT)
        else $error("flag kept after a low sample");

    a_state_frozen: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !CE_IN |=> $stable(st_reg))
        else $error("state moved with enable low");

    a_flag_frozen: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !CE_IN |=> $stable(OV_FLAG_OUT))
        else $error("flag moved with enable low");

endmodule : vsense_config

// *** src/vsense_pkg.sv ***
package vsense_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SETPOINT   = 8'h31;
    localparam logic [7:0] ADDR_OV_LIMIT   = 8'h32;
    localparam logic [7:0] ADDR_COMMIT     = 8'h5D;
    localparam int         COMMIT_BIT      = 0;
    localparam logic [7:0] SETPOINT_RESET  = 8'hA5;
    localparam logic [7:0] OV_LIMIT_RESET  = 8'h00;

    // ------------------------------------------------------------
    // Overvoltage limit fields
    // ------------------------------------------------------------
    localparam int         OV_CODE_MSB     = 7;
    localparam int         OV_CODE_LSB     = 3;
    localparam int         RESERVED_BIT    = 2;
    localparam int         COUNT_MSB       = 1;
    localparam int         COUNT_LSB       = 0;
    localparam logic [6:0] THRESH_BASE     = 7'h59;
    localparam int         SAMPLE_WIDTH    = 12;
    localparam int         THRESH_SHIFT    = SAMPLE_WIDTH - 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS   = 20;
    localparam int         SAMPLE_PERIOD_US = 80;
    localparam int         SAMPLE_CYCLES   = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic [7:0]              setpoint_shadow;
        logic [7:0]              setpoint_active;
        logic [7:0]              ov_limit;
        logic [7:0]              rdata;
        logic [11:0]             tick_cnt;
        logic                    tick;
        logic [SAMPLE_WIDTH-1:0] threshold;
    } top_state_type;

    typedef struct packed {
        logic [2:0] run;
        logic       flag;
    } run_state_type;

endpackage : vsense_pkg
